// ### inc/pwm_fault_limit_blanking_cfg.svh
// constants and register map of the pwm fault / current-limit blanking front end
`ifndef PWM_FAULT_LIMIT_BLANKING_CFG_SVH
`define PWM_FAULT_LIMIT_BLANKING_CFG_SVH

`define ADDR_FAULT_LIMIT  8'h00
`define ADDR_EDGE_BLANK   8'h04
`define ADDR_BLANK_DELAY  8'h08
`define ADDR_AUX          8'h0C
`define ADDR_OUT_LEVELS   8'h10
`define ADDR_STATUS       8'h14
`define ADDR_UNLOCK       8'h18

`define UNLOCK_KEY1       16'hAA55
`define UNLOCK_KEY2       16'h55AA

`define FCL_RESET         16'h00F8
`define FCL_WMASK         16'h7FFF
`define LEB_WMASK         16'hFC3F
`define DLY_WMASK         16'h0FFF
`define AUX_WMASK         16'h0F00
`define LVL_WMASK         16'h000F

`define FCL_LIM_SRC_HI    14
`define FCL_LIM_SRC_LO    10
`define FCL_LIM_POL       9
`define FCL_LIM_EN        8
`define FCL_TRIP_SRC_HI   7
`define FCL_TRIP_SRC_LO   3
`define FCL_TRIP_POL      2
`define FCL_TRIP_MODE_HI  1
`define FCL_TRIP_MODE_LO  0

`define LEB_HI_RISE       15
`define LEB_HI_FALL       14
`define LEB_LO_RISE       13
`define LEB_LO_FALL       12
`define LEB_TRIP_EN       11
`define LEB_LIMIT_EN      10
`define LEB_SEL_HIGH      5
`define LEB_SEL_LOW       4
`define LEB_HI_HIGH       3
`define LEB_HI_LOW        2
`define LEB_LO_HIGH       1
`define LEB_LO_LOW        0

`define AUX_SEL_HI        11
`define AUX_SEL_LO        8
`define LVL_TRIP_HI       3
`define LVL_TRIP_LO       2
`define LVL_LIMIT_HI      1
`define LVL_LIMIT_LO      0
`define STAT_CLEAR_LATCH  0

`define SRC_FAULT_LAST    5'h07
`define SRC_COMP_FIRST    5'h08
`define SRC_COMP_LAST     5'h0C
`define SRC_FAULT32       5'h1F
`define BLANK_SEL_NONE    4'h0
`define BLANK_SEL_LAST    4'h3
`define DELAY_W           12

`endif

// ### inc/pwm_fault_limit_blanking_pkg.sv
// types shared by the pwm fault / current-limit blanking front end
package pwm_fault_limit_blanking_pkg;

    typedef enum logic [1:0]
    {
        TRIP_LATCHED = 2'b00,
        TRIP_CYCLE   = 2'b01,
        TRIP_RSVD    = 2'b10,
        TRIP_OFF     = 2'b11
    } trip_mode_t;

    typedef enum logic [1:0]
    {
        UNLOCK_IDLE = 2'b00,
        UNLOCK_HALF = 2'b01,
        UNLOCK_OPEN = 2'b10
    } unlock_t;

endpackage

// ### rtl/blank_delay_counter.sv
// leading-edge blanking down counter, restarted by a trigger pulse
`timescale 1ns/100ps
`default_nettype none
`include "pwm_fault_limit_blanking_cfg.svh"

module blank_delay_counter
(
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic                restart,
    input  wire logic [`DELAY_W-1:0] delay,
    output logic                     busy
);

    logic [`DELAY_W-1:0] count_reg;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            count_reg <= '0;
        else if (restart)
            count_reg <= delay;
        else if (count_reg != '0)
            count_reg <= count_reg - 1'b1;
    end

    // a zero delay gives no blanking at all
    assign busy = (count_reg != '0);

endmodule
`default_nettype wire

// ### rtl/pwm_fault_limit_blanking.sv
// fault and current-limit selection, blanking and output forcing for one pwm generator
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pwm_fault_limit_blanking_cfg.svh"

module pwm_fault_limit_blanking
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // device configuration and generator context
    input  wire logic        pwm_write_lock,
    input  wire logic        pwm_module_on,
    input  wire logic        pwm_cycle_start,
    input  wire logic        pwm_gen_hi,
    input  wire logic        pwm_gen_lo,
    input  wire logic [2:0]  blank_src_hi,
    // protection sources
    input  wire logic [7:0]  fault_in,
    input  wire logic        fault32_in,
    input  wire logic [4:0]  comp_in,
    // protected outputs
    output logic             pwm_out_hi,
    output logic             pwm_out_lo,
    output logic             trip_active,
    output logic             limit_active
);

    logic [15:0]                          fault_limit_control_reg;
    logic [15:0]                          edge_blanking_control_reg;
    logic [15:0]                          blank_delay_reg;
    logic [15:0]                          aux_control_reg;
    logic [15:0]                          out_levels_reg;
    logic [31:0]                          prdata_reg;
    logic                                 trip_latch_reg;
    logic                                 trip_cycle_reg;
    logic                                 limit_cycle_reg;
    logic                                 pwm_out_hi_reg;
    logic                                 pwm_out_lo_reg;
    logic                                 gen_hi_prev_reg;
    logic                                 gen_lo_prev_reg;
    pwm_fault_limit_blanking_pkg::unlock_t unlock_reg;
    pwm_fault_limit_blanking_pkg::unlock_t unlock_next;
    pwm_fault_limit_blanking_pkg::trip_mode_t trip_mode;

    logic        setup_phase;
    logic        access_phase;
    logic        wr_access;
    logic        addr_mapped;
    logic        fcl_locked;
    logic        fcl_write;
    logic        unlock_write;
    logic [15:0] wdata16;
    logic [15:0] rdata_sel;
    logic [15:0] status_word;

    logic [4:0]  limit_src;
    logic [4:0]  trip_src;
    logic        limit_raw;
    logic        trip_raw;
    logic        limit_pol;
    logic        trip_pol;
    logic        limit_asserted;
    logic        trip_asserted;
    logic        leb_restart;
    logic        leb_busy;
    logic        blank_signal;
    logic        state_blank;
    logic        limit_qual;
    logic        trip_qual;
    logic        trip_force;
    logic        limit_force;
    logic        latch_clear;

    // apb slave
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_access    = access_phase && pwrite;
    assign wdata16      = pwdata[15:0];
    // every access completes in its first access cycle
    assign pready       = 1'b1;

    always_comb
    begin
        unique case (paddr)
            `ADDR_FAULT_LIMIT,
            `ADDR_EDGE_BLANK,
            `ADDR_BLANK_DELAY,
            `ADDR_AUX,
            `ADDR_OUT_LEVELS,
            `ADDR_STATUS,
            `ADDR_UNLOCK:     addr_mapped = 1'b1;
            default:          addr_mapped = 1'b0;
        endcase
    end

    assign fcl_locked   = pwm_write_lock
                          && (unlock_reg != pwm_fault_limit_blanking_pkg::UNLOCK_OPEN);
    assign fcl_write    = wr_access && (paddr == `ADDR_FAULT_LIMIT) && !fcl_locked;
    assign unlock_write = wr_access && (paddr == `ADDR_UNLOCK);
    assign pslverr      = access_phase
                          && (!addr_mapped
                              || (pwrite && (paddr == `ADDR_FAULT_LIMIT) && fcl_locked));

    always_comb
    begin
        unlock_next = unlock_reg;
        unique case (unlock_reg)
            pwm_fault_limit_blanking_pkg::UNLOCK_IDLE:
            begin
                if (unlock_write && wdata16 == `UNLOCK_KEY1)
                    unlock_next = pwm_fault_limit_blanking_pkg::UNLOCK_HALF;
            end
            pwm_fault_limit_blanking_pkg::UNLOCK_HALF:
            begin
                if (unlock_write && wdata16 == `UNLOCK_KEY2)
                    unlock_next = pwm_fault_limit_blanking_pkg::UNLOCK_OPEN;
                else if (wr_access)
                    unlock_next = pwm_fault_limit_blanking_pkg::UNLOCK_IDLE;
            end
            pwm_fault_limit_blanking_pkg::UNLOCK_OPEN:
            begin
                // any write spends the unlock, so each write needs a fresh sequence
                if (wr_access)
                    unlock_next = pwm_fault_limit_blanking_pkg::UNLOCK_IDLE;
            end
            default:
                unlock_next = pwm_fault_limit_blanking_pkg::UNLOCK_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            unlock_reg <= pwm_fault_limit_blanking_pkg::UNLOCK_IDLE;
        else
            unlock_reg <= unlock_next;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_limit_control_reg   <= `FCL_RESET;
            edge_blanking_control_reg <= '0;
            blank_delay_reg           <= '0;
            aux_control_reg           <= '0;
            out_levels_reg            <= '0;
        end
        else
        begin
            if (fcl_write)
                fault_limit_control_reg <= wdata16 & `FCL_WMASK;
            if (wr_access && paddr == `ADDR_EDGE_BLANK)
                edge_blanking_control_reg <= wdata16 & `LEB_WMASK;
            if (wr_access && paddr == `ADDR_BLANK_DELAY)
                blank_delay_reg <= wdata16 & `DLY_WMASK;
            if (wr_access && paddr == `ADDR_AUX)
                aux_control_reg <= wdata16 & `AUX_WMASK;
            if (wr_access && paddr == `ADDR_OUT_LEVELS)
                out_levels_reg <= wdata16 & `LVL_WMASK;
        end
    end

    assign status_word = {10'h000,
                          unlock_reg == pwm_fault_limit_blanking_pkg::UNLOCK_OPEN,
                          state_blank,
                          leb_busy,
                          limit_force,
                          trip_force,
                          trip_latch_reg};

    always_comb
    begin
        unique case (paddr)
            `ADDR_FAULT_LIMIT: rdata_sel = fault_limit_control_reg;
            `ADDR_EDGE_BLANK:  rdata_sel = edge_blanking_control_reg;
            `ADDR_BLANK_DELAY: rdata_sel = blank_delay_reg;
            `ADDR_AUX:         rdata_sel = aux_control_reg;
            `ADDR_OUT_LEVELS:  rdata_sel = out_levels_reg;
            `ADDR_STATUS:      rdata_sel = status_word;
            default:           rdata_sel = 16'h0000;
        endcase
    end

    // read data is captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            prdata_reg <= '0;
        else if (setup_phase && !pwrite)
            prdata_reg <= {16'h0000, rdata_sel};
    end

    assign prdata = prdata_reg;

    // source select
    assign limit_src = fault_limit_control_reg[`FCL_LIM_SRC_HI:`FCL_LIM_SRC_LO];
    assign trip_src  = fault_limit_control_reg[`FCL_TRIP_SRC_HI:`FCL_TRIP_SRC_LO];
    assign limit_pol = fault_limit_control_reg[`FCL_LIM_POL];
    assign trip_pol  = fault_limit_control_reg[`FCL_TRIP_POL];
    assign trip_mode = pwm_fault_limit_blanking_pkg::trip_mode_t'(
                       fault_limit_control_reg[`FCL_TRIP_MODE_HI:`FCL_TRIP_MODE_LO]);

    function automatic logic pick_source(input logic [4:0] code,
                                         input logic [7:0] faults,
                                         input logic [4:0] comps,
                                         input logic       fault32);
        logic [4:0] comp_idx;
        comp_idx = code - `SRC_COMP_FIRST;
        if (code <= `SRC_FAULT_LAST)
            pick_source = faults[code[2:0]];
        else if (code <= `SRC_COMP_LAST)
            pick_source = comps[comp_idx[2:0]];
        else if (code == `SRC_FAULT32)
            pick_source = fault32;
        else
            pick_source = 1'b0;
    endfunction

    assign limit_raw = pick_source(limit_src, fault_in, comp_in, fault32_in);
    assign trip_raw  = pick_source(trip_src, fault_in, comp_in, fault32_in);

    assign limit_asserted = limit_raw ^ limit_pol;
    assign trip_asserted  = trip_raw ^ trip_pol;

    // blanking
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gen_hi_prev_reg <= 1'b0;
            gen_lo_prev_reg <= 1'b0;
        end
        else
        begin
            gen_hi_prev_reg <= pwm_gen_hi;
            gen_lo_prev_reg <= pwm_gen_lo;
        end
    end

    assign leb_restart =
        (edge_blanking_control_reg[`LEB_HI_RISE] && pwm_gen_hi && !gen_hi_prev_reg)
        || (edge_blanking_control_reg[`LEB_HI_FALL] && !pwm_gen_hi && gen_hi_prev_reg)
        || (edge_blanking_control_reg[`LEB_LO_RISE] && pwm_gen_lo && !gen_lo_prev_reg)
        || (edge_blanking_control_reg[`LEB_LO_FALL] && !pwm_gen_lo && gen_lo_prev_reg);

    blank_delay_counter blank_delay_counter_i
    (
        .clock   (clock),
        .arst_n  (arst_n),
        .restart (leb_restart),
        .delay   (blank_delay_reg[`DELAY_W-1:0]),
        .busy    (leb_busy)
    );

    always_comb
    begin
        blank_signal = 1'b0;
        if (aux_control_reg[`AUX_SEL_HI:`AUX_SEL_LO] != `BLANK_SEL_NONE
            && aux_control_reg[`AUX_SEL_HI:`AUX_SEL_LO] <= `BLANK_SEL_LAST)
            blank_signal = blank_src_hi[aux_control_reg[`AUX_SEL_LO+1:`AUX_SEL_LO] - 2'b01];
    end

    assign state_blank =
        (edge_blanking_control_reg[`LEB_SEL_HIGH] && blank_signal)
        || (edge_blanking_control_reg[`LEB_SEL_LOW] && !blank_signal
            && aux_control_reg[`AUX_SEL_HI:`AUX_SEL_LO] != `BLANK_SEL_NONE)
        || (edge_blanking_control_reg[`LEB_HI_HIGH] && pwm_gen_hi)
        || (edge_blanking_control_reg[`LEB_HI_LOW] && !pwm_gen_hi)
        || (edge_blanking_control_reg[`LEB_LO_HIGH] && pwm_gen_lo)
        || (edge_blanking_control_reg[`LEB_LO_LOW] && !pwm_gen_lo);

    assign limit_qual = limit_asserted && !state_blank
                        && !(edge_blanking_control_reg[`LEB_LIMIT_EN] && leb_busy);
    assign trip_qual  = trip_asserted && !state_blank
                        && !(edge_blanking_control_reg[`LEB_TRIP_EN] && leb_busy);

    // trip and limit forcing
    assign latch_clear = wr_access && (paddr == `ADDR_STATUS)
                         && wdata16[`STAT_CLEAR_LATCH];

    // latched trip, new trip beats clear
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            trip_latch_reg <= 1'b0;
        else if (trip_qual && trip_mode == pwm_fault_limit_blanking_pkg::TRIP_LATCHED)
            trip_latch_reg <= 1'b1;
        else if (latch_clear
                 || trip_mode != pwm_fault_limit_blanking_pkg::TRIP_LATCHED)
            trip_latch_reg <= 1'b0;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            trip_cycle_reg <= 1'b0;
        else if (trip_qual && trip_mode == pwm_fault_limit_blanking_pkg::TRIP_CYCLE)
            trip_cycle_reg <= 1'b1;
        else if (pwm_cycle_start
                 || trip_mode != pwm_fault_limit_blanking_pkg::TRIP_CYCLE)
            trip_cycle_reg <= 1'b0;
    end

    // limit only when enabled; released at cycle boundary
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            limit_cycle_reg <= 1'b0;
        else if (limit_qual && fault_limit_control_reg[`FCL_LIM_EN])
            limit_cycle_reg <= 1'b1;
        else if (pwm_cycle_start || !fault_limit_control_reg[`FCL_LIM_EN])
            limit_cycle_reg <= 1'b0;
    end

    // off and reserved modes never force
    always_comb
    begin
        unique case (trip_mode)
            pwm_fault_limit_blanking_pkg::TRIP_LATCHED:
                trip_force = trip_latch_reg || trip_qual;
            pwm_fault_limit_blanking_pkg::TRIP_CYCLE:
                trip_force = trip_cycle_reg || trip_qual;
            pwm_fault_limit_blanking_pkg::TRIP_RSVD:
                trip_force = 1'b0;
            pwm_fault_limit_blanking_pkg::TRIP_OFF:
                trip_force = 1'b0;
        endcase
    end

    assign limit_force = fault_limit_control_reg[`FCL_LIM_EN]
                         && (limit_cycle_reg || limit_qual);

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pwm_out_hi_reg <= 1'b0;
            pwm_out_lo_reg <= 1'b0;
        end
        else if (trip_force)
        begin
            pwm_out_hi_reg <= out_levels_reg[`LVL_TRIP_HI];
            pwm_out_lo_reg <= out_levels_reg[`LVL_TRIP_LO];
        end
        else if (limit_force)
        begin
            pwm_out_hi_reg <= out_levels_reg[`LVL_LIMIT_HI];
            pwm_out_lo_reg <= out_levels_reg[`LVL_LIMIT_LO];
        end
        else
        begin
            // module off means the generator drives nothing active
            pwm_out_hi_reg <= pwm_gen_hi && pwm_module_on;
            pwm_out_lo_reg <= pwm_gen_lo && pwm_module_on;
        end
    end

    assign pwm_out_hi   = pwm_out_hi_reg;
    assign pwm_out_lo   = pwm_out_lo_reg;
    assign trip_active  = trip_force;
    assign limit_active = limit_force;

endmodule
`default_nettype wire

// ### bench/fault_source_model.sv
// pin-level model of the external fault inputs and comparator outputs
`timescale 1ns/100ps
`default_nettype none
module fault_source_model
(
    input  wire logic [13:0] act,
    output logic [7:0]       fault_in,
    output logic             fault32_in,
    output logic [4:0]       comp_in
);
    // push-pull sources: the lines always show the commanded level
    assign fault_in   = act[7:0];
    assign comp_in    = act[12:8];
    assign fault32_in = act[13];
endmodule
`default_nettype wire

// ### bench/pwm_fault_limit_blanking_assertions.sv
// port-level checks of the pwm fault / current-limit front end
`timescale 1ns/100ps
`default_nettype none
module pwm_fault_limit_blanking_assertions
(
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pwm_module_on,
    input wire logic        pwm_cycle_start,
    input wire logic        pwm_gen_hi,
    input wire logic        pwm_gen_lo,
    input wire logic        pwm_out_hi,
    input wire logic        pwm_out_lo,
    input wire logic        trip_active,
    input wire logic        limit_active
);
    logic [3:0] lvl_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // shadow of the level register so forced values can be predicted
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            lvl_reg <= 4'h0;
        else if (psel && penable && pwrite && paddr == 8'h10)
            lvl_reg <= pwdata[3:0];
    end
    sequence access_s;
        psel && penable;
    endsequence
    sequence release_s;
        $past(pwm_cycle_start) || $past(psel && penable && pwrite);
    endsequence
    pready_high_a:
        assert property (pready) else $error("pready low");
    upper_zero_a:
        assert property (access_s |-> prdata[31:16] == 16'h0000) else $error("upper read bits set");
    bad_addr_a:
        assert property (access_s ##0 !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
            8'h14, 8'h18}) |-> pslverr) else $error("unmapped access accepted");
    good_addr_a:
        assert property (access_s ##0 (paddr inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18})
            |-> !pslverr) else $error("mapped access refused");
    err_phase_a:
        assert property (pslverr |-> psel && penable) else $error("error outside access");
    trip_force_a:
        assert property (trip_active |=> {pwm_out_hi, pwm_out_lo} == $past(lvl_reg[3:2]))
        else $error("trip levels not driven");
    limit_force_a:
        assert property (limit_active && !trip_active |=> {pwm_out_hi, pwm_out_lo} ==
            $past(lvl_reg[1:0])) else $error("limit levels not driven");
    pwm_follow_a:
        assert property (!trip_active && !limit_active |=> {pwm_out_hi, pwm_out_lo} ==
            $past({pwm_gen_hi, pwm_gen_lo} & {2{pwm_module_on}})) else $error("output not passed");
    trip_release_a:
        assert property ($fell(trip_active) |-> release_s) else $error("trip dropped early");
    limit_release_a:
        assert property ($fell(limit_active) |-> trip_active or release_s)
        else $error("limit dropped early");
endmodule
bind pwm_fault_limit_blanking pwm_fault_limit_blanking_assertions pwm_fault_limit_blanking_assertions_i
(
    .clock(clock), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_module_on(pwm_module_on), .pwm_cycle_start(pwm_cycle_start), .pwm_gen_hi(pwm_gen_hi),
    .pwm_gen_lo(pwm_gen_lo), .pwm_out_hi(pwm_out_hi), .pwm_out_lo(pwm_out_lo),
    .trip_active(trip_active), .limit_active(limit_active)
);
`default_nettype wire

// ### bench/pwm_fault_limit_blanking_tb.sv
// self-checking bench for the pwm fault / current-limit front end
`timescale 1ns/100ps
`default_nettype none
module pwm_fault_limit_blanking_tb;
    logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, err, hit;
    logic        pwm_write_lock, pwm_module_on, pwm_cycle_start, pwm_gen_hi, pwm_gen_lo;
    logic        pwm_out_hi, pwm_out_lo, trip_active, limit_active, fault32_in;
    logic [2:0]  blank_src_hi;
    logic [4:0]  comp_in, code;
    logic [7:0]  paddr, fault_in;
    logic [13:0] act;
    logic [31:0] pwdata, prdata, rd;
    int          miscompares, total_checks;
    pwm_fault_limit_blanking pwm_fault_limit_blanking_i
    (
        .clock(clock), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_write_lock(pwm_write_lock), .pwm_module_on(pwm_module_on),
        .pwm_cycle_start(pwm_cycle_start), .pwm_gen_hi(pwm_gen_hi), .pwm_gen_lo(pwm_gen_lo),
        .blank_src_hi(blank_src_hi), .fault_in(fault_in), .fault32_in(fault32_in),
        .comp_in(comp_in), .pwm_out_hi(pwm_out_hi), .pwm_out_lo(pwm_out_lo),
        .trip_active(trip_active), .limit_active(limit_active)
    );
    fault_source_model fault_source_model_i
    (
        .act(act), .fault_in(fault_in), .fault32_in(fault32_in), .comp_in(comp_in)
    );
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fcl_set(input logic [4:0] ls, input logic lp, input logic le,
                           input logic [4:0] ts, input logic tp, input logic [1:0] tm);
        apb(1'b1, 8'h00, {17'h00000, ls, lp, le, ts, tp, tm});
        step(1);
    endtask
    task automatic boundary();
        @(posedge clock) pwm_cycle_start <= 1'b1;
        @(posedge clock) pwm_cycle_start <= 1'b0;
        step(1);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clock);
        miscompares++;
        print_verdict();
    end
    initial
    begin
        {arst_n, psel, penable, pwrite, pwm_write_lock, pwm_module_on, pwm_cycle_start} = '0;
        {pwm_gen_hi, pwm_gen_lo, paddr, pwdata, blank_src_hi, act} = '0;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0000_00F8);
        apb(1'b0, 8'h1C, 32'h0);
        chk(err, 32'h1);
        apb(1'b1, 8'h04, 32'hFFFF_FFFF);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0000_FC3F);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h10, 32'h9);
        $display("test registers done");
        for (int c = 0; c < 15; c++)
        begin
            code = (c == 14) ? 5'h1F : 5'(c);
            hit  = (code != 5'h0D);
            fcl_set(5'h00, 1'b0, 1'b0, code, 1'b0, 2'b01);
            @(posedge clock) act <= (c == 14) ? 14'h2000 : 14'h0001 << c;
            step(1);
            chk({trip_active, pwm_out_hi, pwm_out_lo}, {hit, hit, 1'b0});
            @(posedge clock) act <= 14'h0000;
            step(1);
            chk(trip_active, hit);
            boundary();
            chk(trip_active, 32'h0);
        end
        $display("test source table done");
        // polarity is only changed with the module off
        fcl_set(5'h00, 1'b0, 1'b0, 5'h00, 1'b1, 2'b01);
        chk(trip_active, 32'h1);
        fcl_set(5'h00, 1'b0, 1'b0, 5'h00, 1'b0, 2'b00);
        @(posedge clock) act <= 14'h0001;
        @(posedge clock) act <= 14'h0000;
        boundary();
        chk(trip_active, 32'h1);
        apb(1'b1, 8'h14, 32'h1);
        step(1);
        chk(trip_active, 32'h0);
        fcl_set(5'h08, 1'b0, 1'b1, 5'h00, 1'b0, 2'b11);
        @(posedge clock) act <= 14'h0101;
        step(1);
        chk({trip_active, limit_active, pwm_out_hi, pwm_out_lo}, 32'h5);
        @(posedge clock) act <= 14'h0000;
        boundary();
        fcl_set(5'h08, 1'b1, 1'b0, 5'h00, 1'b0, 2'b11);
        chk(limit_active, 32'h0);
        fcl_set(5'h08, 1'b1, 1'b1, 5'h00, 1'b0, 2'b11);
        chk(limit_active, 32'h1);
        fcl_set(5'h08, 1'b0, 1'b0, 5'h00, 1'b1, 2'b10);
        chk(trip_active, 32'h0);
        fcl_set(5'h08, 1'b0, 1'b0, 5'h00, 1'b0, 2'b11);
        $display("test modes done");
        @(posedge clock) pwm_write_lock <= 1'b1;
        apb(1'b1, 8'h00, 32'h3);
        chk(err, 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0000_2003);
        apb(1'b1, 8'h18, 32'hAA55);
        apb(1'b1, 8'h18, 32'h55AA);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b0, 8'h00, 32'h0);
        chk({err, rd[30:0]}, 32'h3);
        @(posedge clock) pwm_write_lock <= 1'b0;
        $display("test lock done");
        apb(1'b1, 8'h08, 32'h8);
        apb(1'b1, 8'h04, 32'h8800);
        fcl_set(5'h00, 1'b0, 1'b0, 5'h00, 1'b0, 2'b01);
        @(posedge clock) pwm_gen_hi <= 1'b1;
        @(posedge clock) act <= 14'h0001;
        step(1);
        chk(trip_active, 32'h0);
        step(10);
        chk(trip_active, 32'h1);
        @(posedge clock) act <= 14'h0000;
        boundary();
        apb(1'b1, 8'h0C, 32'h100);
        apb(1'b1, 8'h04, 32'h28);
        @(posedge clock) pwm_module_on <= 1'b1;
        @(posedge clock) act <= 14'h0001;
        step(2);
        chk(trip_active, 32'h0);
        @(posedge clock) blank_src_hi <= 3'h1;
        @(posedge clock) pwm_gen_hi <= 1'b0;
        step(2);
        chk(trip_active, 32'h0);
        @(posedge clock) blank_src_hi <= 3'h0;
        step(1);
        chk(trip_active, 32'h1);
        $display("test blanking done");
        print_verdict();
    end
endmodule
`default_nettype wire
